// ---- hw/cir_top.sv ----
/*
 * Cable interrupt routing block with APB register access, sticky
 * event status, mask and one level interrupt output.
 * Assumes APB master on ref_clk, synchronous active-high reset,
 * all interrupt inputs synchronous and active high.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps

module cir_top import cir_pkg::*; #(
    parameter int NUM_LINES = `CIR_LINES,
    parameter int NUM_SRCS = `CIR_SRCS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cir_lines_t vmeIrqIn,
    input wire logic ptRaise,
    input wire logic dmaDone,
    input wire logic statusError,
    input wire cir_lines_t cableIntIn,
    output cir_lines_t cableIntOut,
    output logic [1:0] vmeIrqOut,
    output logic irq
);
    // ==========================================================
    // Elaboration check
    if (NUM_LINES != `CIR_LINES || NUM_SRCS != `CIR_SRCS) begin : g_bad
        $error("cir_top: line and source counts are fixed");
    end

    // ==========================================================
    // Declarations
    cir_cfg_if cfg ();
    cir_lines_t fwd_ff;
    cir_sel_t ptSel_ff;
    cir_srcs_t map1_ff;
    cir_srcs_t map2_ff;
    cir_sel_t host_ff;
    logic [`CIR_NUM_EVT-1:0] evt_ff;
    logic [`CIR_NUM_EVT-1:0] mask_ff;
    logic [`CIR_NUM_EVT-1:0] evtSet;
    logic [`CIR_NUM_EVT-1:0] evtClr;
    logic [1:0] vmePrev_ff;
    logic hostPrev_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic setup;
    logic access;
    logic wrAccess;
    logic mapped;
    logic legal;
    logic reject;
    cir_lines_t newFwd;
    cir_sel_t newPt;
    cir_srcs_t newMap1;
    cir_srcs_t newMap2;
    cir_sel_t newHost;
    logic [`CIR_ADDR_W-1:0] ofs;

    // ==========================================================
    // Configuration check, shared by every routing write
    function automatic logic cfg_ok(
        input cir_lines_t fwd,
        input cir_sel_t pt,
        input cir_srcs_t m1,
        input cir_srcs_t m2,
        input cir_sel_t host
    );
        cir_lines_t ptL;
        cir_lines_t hostL;
        cir_srcs_t both;
        logic ok;
        ptL = cir_line_dec(pt);
        hostL = cir_line_dec(host);
        both = m1 | m2;
        ok = 1'b1;
        if ((fwd & ptL) != '0) begin
            ok = 1'b0;
        end
        if (((fwd | ptL) & hostL) != '0) begin
            ok = 1'b0;
        end
        if (host == 3'h1 && !both[`CIR_SRC_CI1]) begin
            ok = 1'b0;
        end
        if (host == 3'h2 && !both[`CIR_SRC_CI2]) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // ==========================================================
    // APB decode
    assign ofs = paddr[`CIR_ADDR_W-1:0];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wrAccess = access && pwrite;

    always_comb begin
        case (ofs)
            `CIR_OFS_TXROUTE, `CIR_OFS_RXMAP, `CIR_OFS_HOSTPT,
            `CIR_OFS_STATUS, `CIR_OFS_MASK, `CIR_OFS_LIVE: begin
                mapped = (paddr[31:`CIR_ADDR_W] == '0);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Proposed configuration after this write
    always_comb begin
        newFwd = fwd_ff;
        newPt = ptSel_ff;
        newMap1 = map1_ff;
        newMap2 = map2_ff;
        newHost = host_ff;
        case (ofs)
            `CIR_OFS_TXROUTE: begin
                newFwd = pwdata[`CIR_TX_FWD_LSB +: `CIR_LINES];
                newPt = pwdata[`CIR_TX_PT_LSB +: `CIR_SEL_W];
            end
            `CIR_OFS_RXMAP: begin
                newMap1 = pwdata[`CIR_RX_L1_LSB +: `CIR_SRCS];
                newMap2 = pwdata[`CIR_RX_L2_LSB +: `CIR_SRCS];
            end
            `CIR_OFS_HOSTPT: begin
                newHost = pwdata[`CIR_HOST_LSB +: `CIR_SEL_W];
            end
            default: begin
                newHost = host_ff;
            end
        endcase
        legal = cfg_ok(newFwd, newPt, newMap1, newMap2, newHost);
    end

    // Whole write refused, old routing kept
    assign reject = wrAccess && mapped && !legal;

    // Zero wait states; error on any unmapped access or refused write
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || reject);

    // ==========================================================
    // Routing registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fwd_ff <= `CIR_RST_FWD;
            ptSel_ff <= `CIR_RST_SEL;
        end else if (wrAccess && mapped && legal && ofs == `CIR_OFS_TXROUTE) begin
            fwd_ff <= newFwd;
            ptSel_ff <= newPt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            map1_ff <= `CIR_RST_MAP;
            map2_ff <= `CIR_RST_MAP;
        end else if (wrAccess && mapped && legal && ofs == `CIR_OFS_RXMAP) begin
            map1_ff <= newMap1;
            map2_ff <= newMap2;
        end
    end

    // Mirrors the host's own line choice; host software keeps both in step
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_ff <= `CIR_RST_SEL;
        end else if (wrAccess && mapped && legal && ofs == `CIR_OFS_HOSTPT) begin
            host_ff <= newHost;
        end
    end

    assign cfg.levelFwd = fwd_ff;
    assign cfg.ptLine = ptSel_ff;
    assign cfg.mapLvl1 = map1_ff;
    assign cfg.mapLvl2 = map2_ff;
    assign cfg.hostPtLine = host_ff;

    // ==========================================================
    // Router
    cir_router u_router (
        .ref_clk(ref_clk),
        .reset(reset),
        .cfg(cfg.rtr),
        .vmeIrqIn(vmeIrqIn),
        .ptRaise(ptRaise),
        .dmaDone(dmaDone),
        .statusError(statusError),
        .cableIntIn(cableIntIn)
    );

    assign cableIntOut = cfg.cableIntOut;
    assign vmeIrqOut = cfg.vmeIrqOut;

    // ==========================================================
    // Events: rising edges of routed levels, remote interrupt, refusals
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vmePrev_ff <= 2'h0;
            hostPrev_ff <= 1'b0;
        end else begin
            vmePrev_ff <= cfg.vmeIrqOut;
            hostPrev_ff <= cfg.hostPtSeen;
        end
    end

    always_comb begin
        evtSet = '0;
        evtSet[`CIR_EV_REJECT] = reject;
        evtSet[`CIR_EV_HOSTPT] = cfg.hostPtSeen && !hostPrev_ff;
        evtSet[`CIR_EV_LVL1] = cfg.vmeIrqOut[0] && !vmePrev_ff[0];
        evtSet[`CIR_EV_LVL2] = cfg.vmeIrqOut[1] && !vmePrev_ff[1];
        evtClr = '0;
        if (wrAccess && ofs == `CIR_OFS_STATUS && mapped) begin
            evtClr = pwdata[`CIR_NUM_EVT-1:0];
        end
    end

    // Set beats a same-cycle write-one clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            evt_ff <= `CIR_RST_EVT;
        end else begin
            evt_ff <= (evt_ff & ~evtClr) | evtSet;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_ff <= `CIR_RST_EVT;
        end else if (wrAccess && mapped && ofs == `CIR_OFS_MASK) begin
            mask_ff <= pwdata[`CIR_NUM_EVT-1:0];
        end
    end

    assign irq = |(evt_ff & mask_ff);

    // ==========================================================
    // Read data, captured in setup so it stands through access
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (ofs)
            `CIR_OFS_TXROUTE: begin
                nxt_rdata[`CIR_TX_FWD_LSB +: `CIR_LINES] = fwd_ff;
                nxt_rdata[`CIR_TX_PT_LSB +: `CIR_SEL_W] = ptSel_ff;
            end
            `CIR_OFS_RXMAP: begin
                nxt_rdata[`CIR_RX_L1_LSB +: `CIR_SRCS] = map1_ff;
                nxt_rdata[`CIR_RX_L2_LSB +: `CIR_SRCS] = map2_ff;
            end
            `CIR_OFS_HOSTPT: begin
                nxt_rdata[`CIR_HOST_LSB +: `CIR_SEL_W] = host_ff;
            end
            `CIR_OFS_STATUS: begin
                nxt_rdata[`CIR_NUM_EVT-1:0] = evt_ff;
            end
            `CIR_OFS_MASK: begin
                nxt_rdata[`CIR_NUM_EVT-1:0] = mask_ff;
            end
            `CIR_OFS_LIVE: begin
                nxt_rdata[`CIR_LIVE_CAB_LSB +: `CIR_LINES] = cfg.cableIntOut;
                nxt_rdata[`CIR_LIVE_VME_LSB +: 2] = cfg.vmeIrqOut;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
        if (!mapped) begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign prdata = rdata_ff;
endmodule

// ---- hw/cir_defs.svh ----
/*
 * Offsets, field positions, reset values and widths of the cable
 * interrupt router. Assumes inclusion by bare name from hw/.
 */
`ifndef CIR_DEFS_SVH
`define CIR_DEFS_SVH

// ==========================================================
// Widths
`define CIR_LINES 7
`define CIR_SRCS 5
`define CIR_SEL_W 3
`define CIR_ADDR_W 8
`define CIR_NUM_EVT 4

// ==========================================================
// Register byte offsets
`define CIR_OFS_TXROUTE 8'h00
`define CIR_OFS_RXMAP 8'h04
`define CIR_OFS_HOSTPT 8'h08
`define CIR_OFS_STATUS 8'h0c
`define CIR_OFS_MASK 8'h10
`define CIR_OFS_LIVE 8'h14

// ==========================================================
// Field positions
`define CIR_TX_FWD_LSB 0
`define CIR_TX_PT_LSB 8
`define CIR_RX_L1_LSB 0
`define CIR_RX_L2_LSB 8
`define CIR_HOST_LSB 0
`define CIR_LIVE_CAB_LSB 0
`define CIR_LIVE_VME_LSB 8

// ==========================================================
// Local source positions
`define CIR_SRC_DMA 0
`define CIR_SRC_CI1 1
`define CIR_SRC_CI2 2
`define CIR_SRC_STERR 3
`define CIR_SRC_PT 4

// ==========================================================
// Status event bits
`define CIR_EV_REJECT 0
`define CIR_EV_HOSTPT 1
`define CIR_EV_LVL1 2
`define CIR_EV_LVL2 3

// ==========================================================
// Reset values
`define CIR_RST_FWD 7'h00
`define CIR_RST_SEL 3'h0
`define CIR_RST_MAP 5'h00
`define CIR_RST_EVT 4'h0

`endif

// ---- hw/cir_pkg.sv ----
/*
 * Types and line decode shared by the router and its top.
 * Assumes cir_defs.svh is reachable by bare name.
 */
`include "cir_defs.svh"

package cir_pkg;
    typedef logic [`CIR_LINES-1:0] cir_lines_t;
    typedef logic [`CIR_SRCS-1:0] cir_srcs_t;
    typedef logic [`CIR_SEL_W-1:0] cir_sel_t;

    // Line number 1..7 to one-hot; 0 means no line
    function automatic cir_lines_t cir_line_dec(input cir_sel_t sel);
        cir_lines_t r;
        r = '0;
        if (sel != 3'h0) begin
            r[sel - 3'h1] = 1'b1;
        end
        return r;
    endfunction
endpackage

// ---- hw/cir_cfg_if.sv ----
/*
 * Routing configuration and routed results between top and router.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/100ps

interface cir_cfg_if;
    import cir_pkg::*;
    cir_lines_t levelFwd;
    cir_sel_t ptLine;
    cir_srcs_t mapLvl1;
    cir_srcs_t mapLvl2;
    cir_sel_t hostPtLine;
    cir_lines_t cableIntOut;
    logic [1:0] vmeIrqOut;
    logic hostPtSeen;

    modport ctl (
        output levelFwd, ptLine, mapLvl1, mapLvl2, hostPtLine,
        input cableIntOut, vmeIrqOut, hostPtSeen
    );
    modport rtr (
        input levelFwd, ptLine, mapLvl1, mapLvl2, hostPtLine,
        output cableIntOut, vmeIrqOut, hostPtSeen
    );
endinterface

// ---- hw/cir_router.sv ----
/*
 * Level router: backplane levels and local processor interrupt onto
 * cable lines, five local sources onto backplane levels 1 and 2.
 * Assumes legal configuration from the control side, sync inputs.
 */
`timescale 1ns/100ps

module cir_router import cir_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    cir_cfg_if.rtr cfg,
    input wire cir_lines_t vmeIrqIn,
    input wire logic ptRaise,
    input wire logic dmaDone,
    input wire logic statusError,
    input wire cir_lines_t cableIntIn
);
    cir_lines_t cable_ff;
    cir_lines_t nxt_cable;
    logic [1:0] vme_ff;
    logic [1:0] nxt_vme;
    logic remotePt;
    logic pt_ff;
    cir_srcs_t srcs;
    cir_lines_t hostLines;

    // ==========================================================
    // Toward the host
    always_comb begin
        hostLines = cir_line_dec(cfg.hostPtLine);
        nxt_cable = (vmeIrqIn & cfg.levelFwd);
        if (ptRaise) begin
            nxt_cable = nxt_cable | cir_line_dec(cfg.ptLine);
        end
        // Guard even if software slipped a clash through
        nxt_cable = nxt_cable & ~hostLines;
    end

    // ==========================================================
    // Toward the backplane
    always_comb begin
        remotePt = |(cableIntIn & hostLines);
        srcs = '0;
        srcs[`CIR_SRC_DMA] = dmaDone;
        srcs[`CIR_SRC_CI1] = cableIntIn[0];
        srcs[`CIR_SRC_CI2] = cableIntIn[1];
        srcs[`CIR_SRC_STERR] = statusError;
        srcs[`CIR_SRC_PT] = remotePt;
        nxt_vme[0] = |(srcs & cfg.mapLvl1);
        nxt_vme[1] = |(srcs & cfg.mapLvl2);
    end

    // ==========================================================
    // Outputs follow sources, one cycle late, no latching
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cable_ff <= '0;
        end else begin
            cable_ff <= nxt_cable;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vme_ff <= 2'h0;
            pt_ff <= 1'b0;
        end else begin
            vme_ff <= nxt_vme;
            pt_ff <= remotePt;
        end
    end

    assign cfg.cableIntOut = cable_ff;
    assign cfg.vmeIrqOut = vme_ff;
    assign cfg.hostPtSeen = pt_ff;
endmodule

// ---- sim/cir_checker.sv ----
/*
 * Port-level assertions for the cable interrupt router top.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module cir_checker import cir_pkg::*; #(
    parameter int NUM_LINES = 7,
    parameter int NUM_SRCS = 5
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire cir_lines_t vmeIrqIn,
    input wire logic ptRaise,
    input wire logic dmaDone,
    input wire logic statusError,
    input wire cir_lines_t cableIntIn,
    input wire cir_lines_t cableIntOut,
    input wire logic [1:0] vmeIrqOut,
    input wire logic irq
);
    // ==========================================
    // Sequences
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence acc_s;
        psel && penable;
    endsequence
    sequence bad_s;
        acc_s ##0 (paddr[31:8] != 24'h0);
    endsequence

    // ==========================================
    // Properties
    fwd_only_a: assert property (
        (cableIntOut & ~$past(vmeIrqIn)) != 7'h00 |-> $past(ptRaise))
        else $error("cable line high without source");
    pt_single_a: assert property (
        $onehot0(cableIntOut & ~$past(vmeIrqIn)))
        else $error("processor interrupt on several lines");
    rx_src_a: assert property (
        vmeIrqOut != 2'b00 |-> $past({dmaDone, statusError, cableIntIn}) != 9'h0)
        else $error("backplane level without source");
    // No latching: same inputs and config give the same cable outputs
    tx_stable_a: assert property (
        ($past(vmeIrqIn) == $past(vmeIrqIn, 2) && $past(ptRaise) == $past(ptRaise, 2)
        && !$past(reset) && !$past(reset, 2)
        && !($past(psel, 2) && $past(penable, 2) && $past(pwrite, 2)))
        |-> cableIntOut == $past(cableIntOut))
        else $error("cable outputs changed without cause");
    reset_clear_a: assert property (
        $past(reset) |-> cableIntOut == 7'h00 && vmeIrqOut == 2'b00 && !irq)
        else $error("outputs not clear after reset");
    unmapped_err_a: assert property (bad_s |-> pslverr)
        else $error("unmapped access not refused");
    unmapped_zero_a: assert property (bad_s ##0 !pwrite |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule

bind cir_top cir_checker #(.NUM_LINES(NUM_LINES), .NUM_SRCS(NUM_SRCS)) cir_checker_inst (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .vmeIrqIn(vmeIrqIn),
    .ptRaise(ptRaise), .dmaDone(dmaDone), .statusError(statusError),
    .cableIntIn(cableIntIn), .cableIntOut(cableIntOut), .vmeIrqOut(vmeIrqOut), .irq(irq));

// ---- sim/cir_host_model.sv ----
/*
 * Host-side adapter model: drives its processor interrupt onto one
 * cable line. Assumes the bench picks the line and fires it.
 */
`timescale 1ns/100ps

module cir_host_model import cir_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire cir_sel_t hostSel,
    input wire logic hostFire,
    output cir_lines_t cableIntIn
);
    cir_lines_t hostLines_ff;

    // Only source offered; lines left idle stay inactive low
    always_ff @(posedge ref_clk) begin
        if (reset || !hostFire || hostSel == 3'h0) begin
            hostLines_ff <= 7'h00;
        end else begin
            hostLines_ff <= 7'h01 << (hostSel - 3'h1);
        end
    end
    assign cableIntIn = hostLines_ff;
endmodule

// ---- sim/testbench.sv ----
/*
 * Self-checking bench for the cable interrupt router top.
 * Assumes zero-wait APB slave and registered routing outputs.
 */
`timescale 1ns/100ps

module testbench import cir_pkg::*;;
    logic ref_clk, reset, psel, penable, pwrite, ptRaise, dmaDone, statusError, hostFire;
    logic [31:0] paddr, pwdata, prdata, rdv, r32, seed;
    logic pready, pslverr, irq;
    logic [1:0] vmeIrqOut;
    cir_lines_t vmeIrqIn, cableIntIn, cableIntOut, fwd;
    cir_sel_t hostSel, pt;
    cir_srcs_t m1, m2;
    int n_fail, total_checks;

    cir_top #(.NUM_LINES(7), .NUM_SRCS(5)) cir_top_inst (.ref_clk(ref_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vmeIrqIn(vmeIrqIn),
        .ptRaise(ptRaise), .dmaDone(dmaDone), .statusError(statusError),
        .cableIntIn(cableIntIn), .cableIntOut(cableIntOut), .vmeIrqOut(vmeIrqOut), .irq(irq));
    cir_host_model cir_host_model_inst (.ref_clk(ref_clk), .reset(reset), .hostSel(hostSel),
        .hostFire(hostFire), .cableIntIn(cableIntIn));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ==========================================
    // Helpers
    function automatic cir_lines_t hot(input cir_sel_t s);
        return (s == 3'h0) ? 7'h00 : 7'h01 << (s - 3'h1);
    endfunction
    function automatic cir_lines_t expTx(input cir_lines_t f, v, input cir_sel_t p, h,
        input logic r);
        return ((f & v) | (r ? hot(p) : 7'h00)) & ~hot(h);
    endfunction
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task final_report;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [31:0] a, d, input logic xe);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdv = prdata;
        check(pslverr === xe);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            n_fail++;
            final_report();
        end
    endtask
    task settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    // Drives one local source; host line 5 stands for the remote one
    task src(input int s, input logic on);
        @(posedge ref_clk);
        dmaDone <= on && s == 0;
        statusError <= on && s == 3;
        hostSel <= (s == 1) ? 3'h1 : (s == 2) ? 3'h2 : 3'h5;
        hostFire <= on && (s == 1 || s == 2 || s == 4);
    endtask

    // ==========================================
    // Sequence
    initial begin
        seed = 32'hbf52e404;
        n_fail = 0;
        total_checks = 0;
        {reset, psel, penable, pwrite, paddr, pwdata} = {3'b100, 1'b0, 64'h0};
        {vmeIrqIn, ptRaise, dmaDone, statusError, hostFire, hostSel} = 14'h0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        for (int a = 0; a < 24; a += 4) begin
            acc(1'b0, a, 32'h0, 1'b0);
            check(rdv === 32'h0);
        end
        acc(1'b0, 32'h100, 32'h0, 1'b1);
        check(rdv === 32'h0);
        acc(1'b1, 32'h100, 32'h1, 1'b1);
        for (int i = 0; i < 24; i++) begin
            r32 = rnd();
            pt = r32[10:8];
            fwd = r32[6:0] & ~hot(r32[10:8]);
            acc(1'b1, 32'h0, {21'h0, pt, 1'b0, fwd}, 1'b0);
            r32 = rnd();
            @(posedge ref_clk);
            vmeIrqIn <= r32[6:0];
            ptRaise <= r32[7];
            settle;
            check(cableIntOut === expTx(fwd, r32[6:0], pt, 3'h0, r32[7]));
            acc(1'b1, 32'h0, {21'h0, 3'h7, 8'h40}, 1'b1);
            acc(1'b0, 32'h0, 32'h0, 1'b0);
            check(rdv === {21'h0, pt, 1'b0, fwd});
        end
        acc(1'b0, 32'hc, 32'h0, 1'b0);
        check(rdv[0] === 1'b1);
        @(posedge ref_clk);
        vmeIrqIn <= 7'h00;
        ptRaise <= 1'b0;
        settle;
        check(cableIntOut === 7'h00);
        acc(1'b1, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 32'h8, 32'h5, 1'b0);
        acc(1'b1, 32'h0, 32'h10, 1'b1);
        acc(1'b1, 32'h0, 32'h500, 1'b1);
        acc(1'b1, 32'h0, 32'h6f, 1'b0);
        @(posedge ref_clk);
        vmeIrqIn <= 7'h7f;
        settle;
        check(cableIntOut === 7'h6f);
        acc(1'b0, 32'h14, 32'h0, 1'b0);
        check(rdv === 32'h0000_006f);
        @(posedge ref_clk);
        vmeIrqIn <= 7'h00;
        for (int i = 0; i < 12; i++) begin
            r32 = rnd();
            m1 = r32[4:0];
            m2 = r32[12:8];
            acc(1'b1, 32'h4, {19'h0, m2, 3'h0, m1}, 1'b0);
            for (int s = 0; s < 5; s++) begin
                src(s, 1'b1);
                settle;
                check(vmeIrqOut === {m2[s], m1[s]});
                src(s, 1'b0);
                settle;
                check(vmeIrqOut === 2'b00);
            end
        end
        acc(1'b1, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 32'h4, 32'h0, 1'b0);
        acc(1'b1, 32'h8, 32'h1, 1'b1);
        acc(1'b1, 32'h4, 32'h2, 1'b0);
        acc(1'b1, 32'h8, 32'h1, 1'b0);
        acc(1'b1, 32'hc, 32'hf, 1'b0);
        acc(1'b1, 32'h10, 32'h4, 1'b0);
        src(1, 1'b1);
        settle;
        check(vmeIrqOut === 2'b01);
        settle;
        check(irq === 1'b1);
        acc(1'b1, 32'h10, 32'h0, 1'b0);
        settle;
        check(irq === 1'b0);
        acc(1'b0, 32'hc, 32'h0, 1'b0);
        check(rdv === 32'h0000_0006);
        acc(1'b1, 32'h10, 32'h4, 1'b0);
        settle;
        check(irq === 1'b1);
        acc(1'b1, 32'hc, 32'h4, 1'b0);
        settle;
        check(irq === 1'b0);
        src(1, 1'b0);
        settle;
        final_report();
    end
endmodule
